// ---- rtl/lcbt_pkg.sv ----
// Purpose: Shared constants for the bias timing configuration bank
// Assumes: 100 MHz mclk_i, APB with 32-bit data
// Notes:   Byte address of a register is four times its index
package lcbt_pkg;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned ADDR_W       = 8;
  // Register indices
  localparam logic [5:0] IDX_GATE_DLY  = 6'h0D;
  localparam logic [5:0] IDX_OVP_LIM   = 6'h0E;
  localparam logic [5:0] IDX_DIM_FREQ  = 6'h0F;
  localparam logic [5:0] IDX_RST_PULSE = 6'h10;
  localparam logic [5:0] IDX_STATUS    = 6'h14;
  // Field layouts
  localparam int unsigned NIB_W        = 4;
  localparam int unsigned OVP_W        = 2;
  // Reset values
  localparam logic [3:0] RST_GATE_DLY  = 4'h2;
  localparam logic [1:0] RST_OVP_LIM   = 2'h1;
  localparam logic [3:0] RST_DIM_FREQ  = 4'h7;
  localparam logic [3:0] RST_RST_PULSE = 4'h0;
  // Status bit positions
  localparam int unsigned ST_GATE_EN   = 0;
  localparam int unsigned ST_GATE_BUSY = 1;
  localparam int unsigned ST_PNL_RST   = 2;
  localparam int unsigned ST_GATE_PIN  = 3;
  // Timing
  localparam int unsigned GATE_STEP_MS = 5;
  localparam int unsigned RST_STEP_MS  = 1;
  localparam int unsigned DIM_BASE_HZ  = 15_000;
  localparam int unsigned DIM_STEP_HZ  = 1_000;
  localparam logic [2:0]  DIM_MAX_CODE = 3'h7;
  localparam int unsigned GATE_UNIT_CYC = CLK_HZ / 1000 * GATE_STEP_MS;
  localparam int unsigned RST_UNIT_CYC  = CLK_HZ / 1000 * RST_STEP_MS;
  localparam int unsigned SYNC_STAGES   = 3;

  typedef enum logic [2:0] {
    TMR_IDLE = 3'b001,
    TMR_RUN  = 3'b010,
    TMR_DONE = 3'b100
  } lcbt_tmr_state_e;
endpackage : lcbt_pkg

// ---- rtl/lcbt_timer_if.sv ----
// Purpose: Start/abort and progress of one unit timer
// Assumes: Single clock domain
// Notes:   ctrl side drives the request, tmr side answers
`timescale 1ns/1ps
interface lcbt_timer_if;
  logic       start;
  logic       abort;
  logic [3:0] units;
  logic       busy;
  logic       done;
  modport ctrl (output start, output abort, output units, input busy, input done);
  modport tmr  (input start, input abort, input units, output busy, output done);
endinterface : lcbt_timer_if

// ---- rtl/lcbt_unit_timer.sv ----
// Purpose: Counts a code value of fixed time units
// Assumes: UNIT_CYCLES at least 2
// Notes:   Busy lasts exactly units * UNIT_CYCLES cycles unless abort ends it early; starts while active are ignored
`timescale 1ns/1ps
module lcbt_unit_timer #(
  parameter int unsigned UNIT_CYCLES = lcbt_pkg::GATE_UNIT_CYC
) (
  input  wire logic  mclk_i,
  input  wire logic  rst_i,
  lcbt_timer_if.tmr  tmr
);
  localparam int unsigned PW = $clog2(UNIT_CYCLES + 1);

  lcbt_pkg::lcbt_tmr_state_e state_q, state_d;
  logic [PW-1:0]             pre_q, pre_d;
  logic [3:0]                left_q, left_d;

  always_comb begin
    state_d = state_q;
    pre_d   = pre_q;
    left_d  = left_q;
    case (state_q)
      lcbt_pkg::TMR_IDLE: begin
        if (tmr.start) begin
          pre_d   = '0;
          left_d  = tmr.units;
          state_d = (tmr.units == 4'h0) ? lcbt_pkg::TMR_DONE : lcbt_pkg::TMR_RUN;
        end
      end
      lcbt_pkg::TMR_RUN: begin
        if (pre_q == PW'(UNIT_CYCLES - 1)) begin
          pre_d  = '0;
          left_d = left_q - 4'h1;
          if (left_q == 4'h1) begin
            state_d = lcbt_pkg::TMR_DONE;
          end
        end else begin
          pre_d = pre_q + PW'(1);
        end
      end
      lcbt_pkg::TMR_DONE: begin
        state_d = lcbt_pkg::TMR_IDLE;
      end
      default: begin
        state_d = lcbt_pkg::TMR_IDLE;
      end
    endcase
    if (tmr.abort) begin
      state_d = lcbt_pkg::TMR_IDLE;
      pre_d   = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= lcbt_pkg::TMR_IDLE;
      pre_q   <= '0;
      left_q  <= 4'h0;
    end else begin
      state_q <= state_d;
      pre_q   <= pre_d;
      left_q  <= left_d;
    end
  end

  assign tmr.busy = (state_q == lcbt_pkg::TMR_RUN);
  assign tmr.done = (state_q == lcbt_pkg::TMR_DONE);
endmodule : lcbt_unit_timer

// ---- rtl/lcbt_dim_tick.sv ----
// Purpose: Dimming frequency tick generator
// Assumes: Frequencies well below CLK_HZ
// Notes:   Periods round down to whole cycles
`timescale 1ns/1ps
module lcbt_dim_tick #(
  parameter int unsigned CLK_HZ = lcbt_pkg::CLK_HZ
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] code_i,
  output logic            tick_o
);
  localparam int unsigned CW = $clog2(CLK_HZ / lcbt_pkg::DIM_BASE_HZ + 1);

  logic [CW-1:0] per_tbl [8];
  logic [CW-1:0] cnt_q, cnt_d;
  logic          tick_q, tick_d;
  logic [2:0]    sel;

  for (genvar i = 0; i < 8; i++) begin : g_per
    assign per_tbl[i] = CW'(CLK_HZ / (lcbt_pkg::DIM_BASE_HZ + lcbt_pkg::DIM_STEP_HZ * i));
  end

  // Undefined codes fall back to the top defined code
  assign sel = code_i[3] ? lcbt_pkg::DIM_MAX_CODE : code_i[2:0];

  always_comb begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + CW'(1);
    // Compare with >= so a shorter new period takes effect at once
    if (cnt_q >= per_tbl[sel] - CW'(1)) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
endmodule : lcbt_dim_tick

// ---- rtl/lcbt_config_regs.sv ----
// Purpose: APB bank of bias timing configuration registers and the timing they steer
// Assumes: 100 MHz mclk_i, synchronous active-high rst_i, pins asynchronous to mclk_i
// Notes:   Zero-wait APB; unmapped or misaligned access answers pslverr
`timescale 1ns/1ps
module lcbt_config_regs #(
  parameter int unsigned GATE_UNIT_CYC = lcbt_pkg::GATE_UNIT_CYC,
  parameter int unsigned RST_UNIT_CYC  = lcbt_pkg::RST_UNIT_CYC,
  parameter int unsigned CLK_HZ        = lcbt_pkg::CLK_HZ
) (
  input  wire logic                        mclk_i,
  input  wire logic                        rst_i,
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [lcbt_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                 pwdata_i,
  input  wire logic [3:0]                  pstrb_i,
  output logic [31:0]                      prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o,
  input  wire logic                        gate_shaping_req_i,
  input  wire logic                        panel_reset_req_i,
  output logic                             gate_shaping_en_o,
  output logic                             panel_reset_o,
  output logic [1:0]                       ovp_code_o,
  output logic                             dim_tick_o
);
  localparam int unsigned NPIN = 2;
  localparam int unsigned PIN_GATE = 0;
  localparam int unsigned PIN_RST  = 1;

  // Register select codes
  localparam logic [2:0] SEL_NONE   = 3'h0;
  localparam logic [2:0] SEL_GATE   = 3'h1;
  localparam logic [2:0] SEL_OVP    = 3'h2;
  localparam logic [2:0] SEL_DIM    = 3'h3;
  localparam logic [2:0] SEL_RST    = 3'h4;
  localparam logic [2:0] SEL_STATUS = 3'h5;

  function automatic logic [2:0] reg_sel(input logic [lcbt_pkg::ADDR_W-1:0] addr);
    logic [5:0] idx;
    idx = addr[7:2];
    reg_sel = SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      case (idx)
        lcbt_pkg::IDX_GATE_DLY:  reg_sel = SEL_GATE;
        lcbt_pkg::IDX_OVP_LIM:   reg_sel = SEL_OVP;
        lcbt_pkg::IDX_DIM_FREQ:  reg_sel = SEL_DIM;
        lcbt_pkg::IDX_RST_PULSE: reg_sel = SEL_RST;
        lcbt_pkg::IDX_STATUS:    reg_sel = SEL_STATUS;
        default:                 reg_sel = SEL_NONE;
      endcase
    end
  endfunction : reg_sel

  // ---------------- Configuration fields ----------------
  logic [3:0] gate_dly_q, gate_dly_d;
  logic [1:0] ovp_lim_q,  ovp_lim_d;
  logic [3:0] dim_freq_q, dim_freq_d;
  logic [3:0] rst_len_q,  rst_len_d;
  logic       wr_acc;
  logic [2:0] wr_sel;

  assign wr_acc = psel_i & penable_i & pwrite_i & pstrb_i[0];
  assign wr_sel = reg_sel(paddr_i);

  always_comb begin
    gate_dly_d = gate_dly_q;
    ovp_lim_d  = ovp_lim_q;
    dim_freq_d = dim_freq_q;
    rst_len_d  = rst_len_q;
    if (wr_acc) begin
      case (wr_sel)
        SEL_GATE: gate_dly_d = pwdata_i[3:0];
        SEL_OVP:  ovp_lim_d  = pwdata_i[1:0];
        SEL_DIM:  dim_freq_d = pwdata_i[3:0];
        SEL_RST:  rst_len_d  = pwdata_i[3:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      gate_dly_q <= lcbt_pkg::RST_GATE_DLY;
      ovp_lim_q  <= lcbt_pkg::RST_OVP_LIM;
      dim_freq_q <= lcbt_pkg::RST_DIM_FREQ;
      rst_len_q  <= lcbt_pkg::RST_RST_PULSE;
    end else begin
      gate_dly_q <= gate_dly_d;
      ovp_lim_q  <= ovp_lim_d;
      dim_freq_q <= dim_freq_d;
      rst_len_q  <= rst_len_d;
    end
  end

  // ---------------- Pin synchronisers ----------------
  // Three stages; a level counts only once stages two and three agree
  logic [NPIN-1:0] pin_raw;
  logic [2:0]      sync_q [NPIN];
  logic [2:0]      sync_d [NPIN];
  logic [NPIN-1:0] lvl_q, lvl_d;
  logic [NPIN-1:0] rise;

  assign pin_raw[PIN_GATE] = gate_shaping_req_i;
  assign pin_raw[PIN_RST]  = panel_reset_req_i;

  for (genvar p = 0; p < NPIN; p++) begin : g_sync
    always_comb begin
      sync_d[p] = {sync_q[p][1:0], pin_raw[p]};
      lvl_d[p]  = lvl_q[p];
      rise[p]   = 1'b0;
      if (sync_q[p][1] == sync_q[p][2]) begin
        lvl_d[p] = sync_q[p][2];
        rise[p]  = sync_q[p][2] & ~lvl_q[p];
      end
    end

    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        sync_q[p] <= 3'h0;
        lvl_q[p]  <= 1'b0;
      end else begin
        sync_q[p] <= sync_d[p];
        lvl_q[p]  <= lvl_d[p];
      end
    end
  end

  // ---------------- Gate shaping start-up delay ----------------
  lcbt_timer_if gate_t ();

  assign gate_t.start = rise[PIN_GATE];
  assign gate_t.units = gate_dly_q;
  // Dropping the request cancels a pending delay; the start cycle still sees the old low level
  assign gate_t.abort = ~lvl_q[PIN_GATE] & ~rise[PIN_GATE];

  lcbt_unit_timer #(
    .UNIT_CYCLES (GATE_UNIT_CYC)
  ) u_gate_tmr (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .tmr    (gate_t)
  );

  logic gate_en_q, gate_en_d;

  always_comb begin
    gate_en_d = gate_en_q;
    if (!lvl_q[PIN_GATE]) begin
      gate_en_d = 1'b0;
    end else if (gate_t.done) begin
      gate_en_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      gate_en_q <= 1'b0;
    end else begin
      gate_en_q <= gate_en_d;
    end
  end

  // ---------------- Controller reset pulse ----------------
  lcbt_timer_if rst_t ();

  assign rst_t.start = rise[PIN_RST];
  assign rst_t.units = rst_len_q;
  assign rst_t.abort = 1'b0;

  lcbt_unit_timer #(
    .UNIT_CYCLES (RST_UNIT_CYC)
  ) u_rst_tmr (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .tmr    (rst_t)
  );

  logic pnl_rst_q, pnl_rst_d;

  always_comb begin
    // Registered copy keeps the width exact, one cycle later
    pnl_rst_d = rst_t.busy;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pnl_rst_q <= 1'b0;
    end else begin
      pnl_rst_q <= pnl_rst_d;
    end
  end

  // ---------------- Dimming frequency ----------------
  lcbt_dim_tick #(
    .CLK_HZ (CLK_HZ)
  ) u_dim (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .code_i (dim_freq_q),
    .tick_o (dim_tick_o)
  );

  // ---------------- Overvoltage threshold ----------------
  logic [1:0] ovp_out_q, ovp_out_d;

  always_comb begin
    ovp_out_d = ovp_lim_q;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ovp_out_q <= lcbt_pkg::RST_OVP_LIM;
    end else begin
      ovp_out_q <= ovp_out_d;
    end
  end

  // ---------------- APB read path ----------------
  // Read data and error are captured in the setup cycle so the access phase needs no wait
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  logic [2:0]  rd_sel;

  assign rd_sel = reg_sel(paddr_i);

  always_comb begin
    rdata_d = rdata_q;
    err_d   = err_q;
    if (psel_i && !penable_i) begin
      rdata_d = 32'h0000_0000;
      err_d   = (rd_sel == SEL_NONE);
      case (rd_sel)
        SEL_GATE: rdata_d[3:0] = gate_dly_q;
        SEL_OVP:  rdata_d[1:0] = ovp_lim_q;
        SEL_DIM:  rdata_d[3:0] = dim_freq_q;
        SEL_RST:  rdata_d[3:0] = rst_len_q;
        SEL_STATUS: begin
          rdata_d[lcbt_pkg::ST_GATE_EN]   = gate_en_q;
          rdata_d[lcbt_pkg::ST_GATE_BUSY] = gate_t.busy;
          rdata_d[lcbt_pkg::ST_PNL_RST]   = pnl_rst_q;
          rdata_d[lcbt_pkg::ST_GATE_PIN]  = lvl_q[PIN_GATE];
        end
        default: begin
        end
      endcase
      // Status is read-only, a write to it is refused
      if (pwrite_i && rd_sel == SEL_STATUS) begin
        err_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & err_q;
  assign prdata_o  = rdata_q;

  assign gate_shaping_en_o = gate_en_q;
  assign panel_reset_o     = pnl_rst_q;
  assign ovp_code_o        = ovp_out_q;
endmodule : lcbt_config_regs

// ---- test/lcbt_config_regs_sva.sv ----
// Purpose: Port-level checks of the bias timing configuration bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound into every lcbt_config_regs instance
`timescale 1ns/1ps
module lcbt_config_regs_sva #(
  parameter int unsigned RST_UNIT_CYC = 10
) (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        gate_shaping_req_i,
  input wire logic        panel_reset_req_i,
  input wire logic        gate_shaping_en_o,
  input wire logic        panel_reset_o,
  input wire logic [1:0]  ovp_code_o,
  input wire logic        dim_tick_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [7:0]  a_ovp;
  logic        acc;
  logic [1:0]  ovp_wr_q;
  logic [1:0]  ovp_wr_d;
  logic [31:0] run_q;
  logic [31:0] run_d;
  assign a_ovp = {lcbt_pkg::IDX_OVP_LIM, 2'b00};
  assign acc   = psel_i && penable_i;
  // Remember the written code so a late copy can still be checked
  always_comb ovp_wr_d = (acc && pwrite_i && pstrb_i[0] && paddr_i == a_ovp) ? pwdata_i[1:0] : ovp_wr_q;
  always_comb run_d = panel_reset_o ? run_q + 32'h0000_0001 : 32'h0000_0000;
  always_ff @(posedge mclk_i) begin
    ovp_wr_q <= ovp_wr_d;
    run_q    <= rst_i ? 32'h0000_0000 : run_d;
  end
  pready_high_a: assert property (pready_o) else $error("pready low");
  ovp_follows_a: assert property (acc && pwrite_i && pstrb_i[0] && paddr_i == a_ovp
    |-> ##2 ovp_code_o == ovp_wr_q) else $error("ovp code not updated");
  nibble_upper_a: assert property (acc && !pwrite_i && paddr_i != a_ovp && paddr_i >= 8'h34
    && paddr_i <= 8'h40 |-> prdata_o[31:4] == 28'h0) else $error("upper bits not zero");
  ovp_upper_a: assert property (acc && !pwrite_i && paddr_i == a_ovp
    |-> prdata_o[31:2] == 30'h0) else $error("ovp upper bits not zero");
  dim_pulse_a: assert property (dim_tick_o |=> !dim_tick_o [*8]) else $error("tick too long");
  pulse_bound_a: assert property (panel_reset_o |-> run_q < 15 * RST_UNIT_CYC)
    else $error("reset pulse too long");
  pulse_cause_a: assert property ($rose(panel_reset_o) |-> $past(panel_reset_req_i, 3))
    else $error("reset pulse without request");
  gate_drop_a: assert property (!gate_shaping_req_i [*8] |-> !gate_shaping_en_o)
    else $error("gate enable without request");
  gate_cause_a: assert property ($rose(gate_shaping_en_o) |-> $past(gate_shaping_req_i, 3))
    else $error("gate enable too early");
  unmapped_err_a: assert property (acc && paddr_i == 8'hFC |-> pslverr_o) else $error("no slave error");
endmodule : lcbt_config_regs_sva

bind lcbt_config_regs lcbt_config_regs_sva #(.RST_UNIT_CYC(RST_UNIT_CYC)) sva_u (
  .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .gate_shaping_req_i(gate_shaping_req_i), .panel_reset_req_i(panel_reset_req_i),
  .gate_shaping_en_o(gate_shaping_en_o), .panel_reset_o(panel_reset_o), .ovp_code_o(ovp_code_o),
  .dim_tick_o(dim_tick_o));

// ---- test/lcd_bias_timing_config_regs_test.sv ----
// Purpose: Self-checking bench of the bias timing configuration bank
// Assumes: Short unit counts; 1 MHz notional rate for dimming periods
// Notes:   Table rows first, timing cases by hand after
`timescale 1ns/1ps
module lcd_bias_timing_config_regs_test;
  localparam int unsigned GATE_CYC = 20;
  localparam int unsigned RST_CYC  = 10;
  localparam int unsigned SIM_HZ   = 1_000_000;
  typedef struct {logic wr; logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata;} lcbt_row_s;
  logic        mclk_i             = 1'b0;
  logic        rst_i              = 1'b1;
  logic        psel_i             = 1'b0;
  logic        penable_i          = 1'b0;
  logic        pwrite_i           = 1'b0;
  logic [7:0]  paddr_i            = 8'h00;
  logic [31:0] pwdata_i           = 32'h0;
  logic [3:0]  pstrb_i            = 4'h0;
  logic        gate_shaping_req_i = 1'b0;
  logic        panel_reset_req_i  = 1'b0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        gate_shaping_en_o;
  logic        panel_reset_o;
  logic [1:0]  ovp_code_o;
  logic        dim_tick_o;
  logic [31:0] rd;
  logic        err;
  int          n;
  int          hi;
  int          miscompares  = 0;
  int          total_checks = 0;
  // First four rows read the reset contents
  lcbt_row_s rows [11] = '{'{0, 8'h34, 8'h00, 8'h02}, '{0, 8'h38, 8'h00, 8'h01}, '{0, 8'h3C, 8'h00, 8'h07},
    '{0, 8'h40, 8'h00, 8'h00}, '{1, 8'h34, 8'hF6, 8'h06}, '{1, 8'h34, 8'h57, 8'h07}, '{1, 8'h38, 8'hFF, 8'h03},
    '{1, 8'h38, 8'hFE, 8'h02}, '{1, 8'h3C, 8'hA5, 8'h05}, '{1, 8'h40, 8'hFF, 8'h0F}, '{1, 8'h40, 8'hC0, 8'h00}};
  int pulse_codes [2] = '{3, 15};
  int delay_codes [2] = '{0, 7};

  always #5 mclk_i = ~mclk_i;

  lcbt_config_regs #(.GATE_UNIT_CYC(GATE_CYC), .RST_UNIT_CYC(RST_CYC), .CLK_HZ(SIM_HZ)) dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .gate_shaping_req_i(gate_shaping_req_i), .panel_reset_req_i(panel_reset_req_i),
    .gate_shaping_en_o(gate_shaping_en_o), .panel_reset_o(panel_reset_o), .ovp_code_o(ovp_code_o),
    .dim_tick_o(dim_tick_o));

  task automatic summarize();
    $display("Checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Entered just after a rising edge; leaves one idle cycle so no signal is driven twice per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    pstrb_i   <= s;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (pready_o !== 1'b1) begin
      miscompares++;
      summarize();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask : apb

  function automatic logic pick(input int sel);
    return sel == 0 ? dim_tick_o : (sel == 1 ? panel_reset_o : gate_shaping_en_o);
  endfunction : pick

  task automatic wait_sig(input int sel, input logic lvl);
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pick(sel) !== lvl && n < 400);
    if (pick(sel) !== lvl) begin
      miscompares++;
      summarize();
    end
  endtask : wait_sig

  initial begin
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    foreach (rows[i]) begin
      if (rows[i].wr) apb(1'b1, rows[i].addr, {24'hFFFFFF, rows[i].wdata}, 4'hF);
      apb(1'b0, rows[i].addr, 32'h0, 4'hF);
      chk("reg_read", {24'h0, rows[i].rdata}, rd);
    end
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 8'h38, c, 4'hF);
      @(posedge mclk_i);
      chk("ovp_code", c, {30'h0, ovp_code_o});
    end
    apb(1'b1, 8'h38, 32'h0, 4'h0);
    apb(1'b0, 8'h38, 32'h0, 4'hF);
    chk("strobe_off_write", 32'h3, rd);
    apb(1'b0, 8'hFC, 32'h0, 4'hF);
    chk("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b1, 8'h50, 32'h0, 4'hF);
    chk("status_wr_err", 32'h1, {31'h0, err});
    for (int c = 0; c < 8; c += 7) begin
      apb(1'b1, 8'h3C, c, 4'hF);
      wait_sig(0, 1'b1);
      wait_sig(0, 1'b1);
      wait_sig(0, 1'b1);
      chk("dim_period", SIM_HZ / (lcbt_pkg::DIM_BASE_HZ + lcbt_pkg::DIM_STEP_HZ * c), n);
    end
    foreach (pulse_codes[i]) begin
      apb(1'b1, 8'h40, pulse_codes[i], 4'hF);
      panel_reset_req_i <= 1'b1;
      wait_sig(1, 1'b1);
      wait_sig(1, 1'b0);
      chk("pulse_len", pulse_codes[i] * RST_CYC, n);
      panel_reset_req_i <= 1'b0;
      repeat (8) @(posedge mclk_i);
    end
    apb(1'b1, 8'h40, 32'h0, 4'hF);
    panel_reset_req_i <= 1'b1;
    hi = 0;
    repeat (20) begin
      @(posedge mclk_i);
      hi += int'(panel_reset_o === 1'b1);
    end
    chk("pulse_none", 32'h0, hi);
    foreach (delay_codes[i]) begin
      apb(1'b1, 8'h34, delay_codes[i], 4'hF);
      gate_shaping_req_i <= 1'b1;
      wait_sig(2, 1'b1);
      hi = int'(n >= delay_codes[i] * GATE_CYC && n <= delay_codes[i] * GATE_CYC + 8);
      chk("gate_delay_window", 32'h1, hi);
      apb(1'b0, 8'h50, 32'h0, 4'hF);
      chk("status_gate_on", 32'h9, rd);
      gate_shaping_req_i <= 1'b0;
      repeat (8) @(posedge mclk_i);
      chk("gate_off", 32'h0, {31'h0, gate_shaping_en_o});
    end
    // Mid-run reset must bring back the default code
    rst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    apb(1'b0, 8'h38, 32'h0, 4'hF);
    chk("ovp_after_reset", 32'h1, rd);
    chk("ovp_code_after_reset", 32'h1, {30'h0, ovp_code_o});
    summarize();
  end
endmodule : lcd_bias_timing_config_regs_test
